// ===== rtl/mpi_regs.svh
// register offsets, field positions and reset values of the modem pin block
// Functional notes
// - the modem status register shows the carrier-detect input level in bit 7 on every read.
// - modem status bit 3 is set when carrier-detect changed level since the last status read.
// - with the modem status interrupt enabled, a change on carrier-detect or data-set-ready raises an interrupt.
// - the modem status register shows the data-set-ready input level in bit 5 on every read.
// - modem status bit 1 is set when data-set-ready changed level since the last status read.
// - the transceiver drive-off output is low whenever the cpu is not reading data.
// - setting the terminal-ready bit of the modem control register drives the terminal-ready output low.
// - terminal-ready goes inactive on master reset, in loop mode, or when its control bit is cleared.
// - the interrupt output is high for any enabled cause: receiver error, data available, fifo-mode time-out, empty holding register, modem status change.
// - the interrupt output drops once the pending cause is serviced, and on master reset.
// - while master reset is high most registers clear and the outputs take their reset levels.
// - setting modem control bit 2 or bit 3 drives user output a or b low.
// - both user outputs go high on master reset, in loop mode, or when their control bit is cleared.
`ifndef MPI_REGS_SVH
`define MPI_REGS_SVH

// register addresses on the 3-bit register port
`define MPI_ADDR_INT_ENABLE  3'h1
`define MPI_ADDR_INT_IDENT   3'h2
`define MPI_ADDR_MODEM_CTRL  3'h4
`define MPI_ADDR_MODEM_STAT  3'h6

// interrupt enable fields
`define MPI_IE_RXDATA        0
`define MPI_IE_THRE          1
`define MPI_IE_LINE          2
`define MPI_IE_MODEM         3

// modem control fields
`define MPI_MC_DTR           0
`define MPI_MC_RTS           1
`define MPI_MC_USER_A        2
`define MPI_MC_USER_B        3
`define MPI_MC_LOOP          4
`define MPI_MC_WIDTH         5

// modem status fields
`define MPI_MS_DSR_DELTA     1
`define MPI_MS_DCD_DELTA     3
`define MPI_MS_DSR_LEVEL     5
`define MPI_MS_DCD_LEVEL     7

// interrupt identification codes
`define MPI_ID_NONE          8'h01
`define MPI_ID_LINE          8'h06
`define MPI_ID_RXDATA        8'h04
`define MPI_ID_TIMEOUT       8'h0c
`define MPI_ID_THRE          8'h02
`define MPI_ID_MODEM         8'h00
`define MPI_ID_FIFO_FLAGS    8'hc0

// reset values
`define MPI_RST_BYTE         8'h00
`define MPI_RST_IE           4'h0
`define MPI_RST_MC           5'h00

// synchroniser lanes: carrier-detect, data-set-ready, master reset
`define MPI_SYNC_WIDTH       3
`define MPI_LANE_DCD         0
`define MPI_LANE_DSR         1
`define MPI_LANE_MRST        2

`endif

// ===== rtl/mpi_pkg.sv
// shared types of the modem pin block
package mpi_pkg;

   typedef logic [7:0] mpi_byte_t;
   typedef logic [2:0] mpi_addr_t;

   // highest pending interrupt cause, one-hot
   typedef enum logic [4:0] {
      MPI_CAUSE_NONE  = 5'b00001,
      MPI_CAUSE_LINE  = 5'b00010,
      MPI_CAUSE_RXD   = 5'b00100,
      MPI_CAUSE_THRE  = 5'b01000,
      MPI_CAUSE_MODEM = 5'b10000
   } mpi_cause_t;

endpackage

// ===== rtl/mpi_sync.sv
// two-flop synchronisers with change detection for the modem pins
`include "mpi_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module mpi_sync
(
   input  wire logic                       clk_i,     // block clock
   input  wire logic                       resetn_i,  // async reset, active low
   input  wire logic [`MPI_SYNC_WIDTH-1:0] async_i,   // raw pin levels
   output logic      [`MPI_SYNC_WIDTH-1:0] level_o,   // synchronised levels
   output logic      [`MPI_SYNC_WIDTH-1:0] change_o   // one-cycle pulse per change
);

   genvar g;

   generate
      for (g = 0; g < `MPI_SYNC_WIDTH; g = g + 1)
      begin : lane
         logic meta_q;
         logic meta_d;
         logic sync_q;
         logic sync_d;
         logic last_q;
         logic last_d;
         // reset to the pin's idle level so no false change follows reset
         localparam logic idle_lvl = (g == `MPI_LANE_MRST) ? 1'b0 : 1'b1;

         // next values: first stage only feeds the second
         always_comb
         begin
            meta_d = async_i[g];
            sync_d = meta_q;
            last_d = sync_q;
         end

         // register stages
         always_ff @(posedge clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
            begin
               meta_q <= idle_lvl;
               sync_q <= idle_lvl;
               last_q <= idle_lvl;
            end
            else
            begin
               meta_q <= meta_d;
               sync_q <= sync_d;
               last_q <= last_d;
            end
         end

         // edge detect on the settled stages only
         assign level_o[g]  = sync_q;
         assign change_o[g] = sync_q ^ last_q;
      end
   endgenerate

endmodule
`default_nettype wire

// ===== rtl/mpi_top.sv
// modem control and status pins, interrupt output and register port
`include "mpi_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module mpi_top
(
   input  wire logic           CLK_I,               // 40 mhz clock
   input  wire logic           RESETN_I,            // async reset, active low
   input  wire logic           MASTER_RESET_I,      // master reset pin, active high
   input  wire logic [2:0]     ADDR_I,              // register address
   input  wire logic [7:0]     WDATA_I,             // write data
   input  wire logic           WR_I,                // write strobe
   input  wire logic           RD_I,                // read strobe
   output logic      [7:0]     RDATA_O,             // read data, cycle after strobe
   input  wire logic           DCD_N_I,             // carrier detect pin, active low
   input  wire logic           DSR_N_I,             // data set ready pin, active low
   input  wire logic           RX_ERROR_I,          // receiver error level
   input  wire logic           RX_AVAIL_I,          // receive data available level
   input  wire logic           RX_TIMEOUT_I,        // receive time-out level
   input  wire logic           FIFO_MODE_I,         // fifo mode enabled
   input  wire logic           THR_EMPTY_I,         // transmit holding register empty
   output logic                DTR_N_O,             // terminal ready, active low
   output logic                RTS_CTRL_O,          // stored request-to-send bit
   output logic                LOOP_O,              // loop mode bit
   output logic                USER_OUTPUT_A_N_O,   // user output a, active low
   output logic                USER_OUTPUT_B_N_O,   // user output b, active low
   output logic                XCVR_DRIVE_OFF_N_O,  // low when cpu not reading
   output logic                INT_O                // interrupt request, active high
);

   // synchronised pins
   logic [`MPI_SYNC_WIDTH-1:0] pin_raw;
   logic [`MPI_SYNC_WIDTH-1:0] pin_level;
   logic [`MPI_SYNC_WIDTH-1:0] pin_change;
   logic                       dcd_on;
   logic                       dsr_on;
   logic                       mrst;

   // register state
   logic [3:0]                 ie_q;
   logic [3:0]                 ie_d;
   logic [`MPI_MC_WIDTH-1:0]   mc_q;
   logic [`MPI_MC_WIDTH-1:0]   mc_d;
   logic                       dcd_delta_q;
   logic                       dcd_delta_d;
   logic                       dsr_delta_q;
   logic                       dsr_delta_d;
   logic                       thre_q;
   logic                       thre_d;
   logic                       thre_last_q;
   logic                       thre_last_d;

   // output flops
   mpi_pkg::mpi_byte_t         rdata_q;
   mpi_pkg::mpi_byte_t         rdata_d;
   logic                       dtr_n_q;
   logic                       dtr_n_d;
   logic                       usr_a_n_q;
   logic                       usr_a_n_d;
   logic                       usr_b_n_q;
   logic                       usr_b_n_d;
   logic                       drv_off_n_q;
   logic                       drv_off_n_d;
   logic                       int_q;
   logic                       int_d;

   // decoded accesses
   logic                       rd_stat;
   logic                       rd_ident;
   logic                       wr_ie;
   logic                       wr_mc;
   logic                       loop_on;

   // interrupt causes
   logic                       line_pend;
   logic                       rxd_pend;
   logic                       thre_pend;
   logic                       modem_pend;
   mpi_pkg::mpi_cause_t        cause;
   mpi_pkg::mpi_byte_t         ident_code;
   mpi_pkg::mpi_byte_t         stat_byte;

   // pin lanes into the synchroniser
   assign pin_raw[`MPI_LANE_DCD]  = DCD_N_I;
   assign pin_raw[`MPI_LANE_DSR]  = DSR_N_I;
   assign pin_raw[`MPI_LANE_MRST] = MASTER_RESET_I;

   mpi_sync u_sync
   (
      .clk_i    (CLK_I),
      .resetn_i (RESETN_I),
      .async_i  (pin_raw),
      .level_o  (pin_level),
      .change_o (pin_change)
   );

   // asserted-true views of the pins
   assign dcd_on  = ~pin_level[`MPI_LANE_DCD];
   assign dsr_on  = ~pin_level[`MPI_LANE_DSR];
   assign mrst    = pin_level[`MPI_LANE_MRST];
   assign loop_on = mc_q[`MPI_MC_LOOP];

   // address decode of the strobes
   assign rd_stat  = RD_I && (ADDR_I == `MPI_ADDR_MODEM_STAT);
   assign rd_ident = RD_I && (ADDR_I == `MPI_ADDR_INT_IDENT);
   assign wr_ie    = WR_I && (ADDR_I == `MPI_ADDR_INT_ENABLE);
   assign wr_mc    = WR_I && (ADDR_I == `MPI_ADDR_MODEM_CTRL);

   // enabled interrupt causes
   assign line_pend  = ie_q[`MPI_IE_LINE] && RX_ERROR_I;
   assign rxd_pend   = ie_q[`MPI_IE_RXDATA] && (RX_AVAIL_I || (RX_TIMEOUT_I && FIFO_MODE_I));
   assign thre_pend  = ie_q[`MPI_IE_THRE] && thre_q;
   assign modem_pend = ie_q[`MPI_IE_MODEM] && (dcd_delta_q || dsr_delta_q);

   // priority of the pending causes
   always_comb
   begin
      if (line_pend)
         cause = mpi_pkg::MPI_CAUSE_LINE;
      else if (rxd_pend)
         cause = mpi_pkg::MPI_CAUSE_RXD;
      else if (thre_pend)
         cause = mpi_pkg::MPI_CAUSE_THRE;
      else if (modem_pend)
         cause = mpi_pkg::MPI_CAUSE_MODEM;
      else
         cause = mpi_pkg::MPI_CAUSE_NONE;
   end

   // identification byte for the top cause
   always_comb
   begin
      case (cause)
         mpi_pkg::MPI_CAUSE_LINE:  ident_code = `MPI_ID_LINE;
         mpi_pkg::MPI_CAUSE_RXD:   ident_code = RX_AVAIL_I ? `MPI_ID_RXDATA : `MPI_ID_TIMEOUT;
         mpi_pkg::MPI_CAUSE_THRE:  ident_code = `MPI_ID_THRE;
         mpi_pkg::MPI_CAUSE_MODEM: ident_code = `MPI_ID_MODEM;
         default:                  ident_code = `MPI_ID_NONE;
      endcase
      if (FIFO_MODE_I)
         ident_code = ident_code | `MPI_ID_FIFO_FLAGS;
   end

   // modem status byte, unused bits zero
   always_comb
   begin
      stat_byte                    = `MPI_RST_BYTE;
      stat_byte[`MPI_MS_DCD_LEVEL] = dcd_on;
      stat_byte[`MPI_MS_DSR_LEVEL] = dsr_on;
      stat_byte[`MPI_MS_DCD_DELTA] = dcd_delta_q;
      stat_byte[`MPI_MS_DSR_DELTA] = dsr_delta_q;
   end

   // next control register values
   always_comb
   begin
      ie_d = ie_q;
      mc_d = mc_q;
      if (wr_ie)
         ie_d = WDATA_I[3:0];
      if (wr_mc)
         mc_d = WDATA_I[`MPI_MC_WIDTH-1:0];
      // writes are dropped while master reset holds
      if (mrst)
      begin
         ie_d = `MPI_RST_IE;
         mc_d = `MPI_RST_MC;
      end
   end

   // control registers
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         ie_q <= `MPI_RST_IE;
         mc_q <= `MPI_RST_MC;
      end
      else
      begin
         ie_q <= ie_d;
         mc_q <= mc_d;
      end
   end

   // next change flags
   always_comb
   begin
      dcd_delta_d = dcd_delta_q;
      dsr_delta_d = dsr_delta_q;
      // a status read clears both flags
      if (rd_stat)
      begin
         dcd_delta_d = 1'b0;
         dsr_delta_d = 1'b0;
      end
      // set wins, so a change during the clearing read is not lost
      if (pin_change[`MPI_LANE_DCD])
         dcd_delta_d = 1'b1;
      if (pin_change[`MPI_LANE_DSR])
         dsr_delta_d = 1'b1;
      if (mrst)
      begin
         dcd_delta_d = 1'b0;
         dsr_delta_d = 1'b0;
      end
   end

   // change flags
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         dcd_delta_q <= 1'b0;
         dsr_delta_q <= 1'b0;
      end
      else
      begin
         dcd_delta_q <= dcd_delta_d;
         dsr_delta_q <= dsr_delta_d;
      end
   end

   // next empty holding register flag
   always_comb
   begin
      thre_d      = thre_q;
      thre_last_d = THR_EMPTY_I;
      // serviced by reading the identification that reports it
      if (rd_ident && (cause == mpi_pkg::MPI_CAUSE_THRE))
         thre_d = 1'b0;
      if (!THR_EMPTY_I)
         thre_d = 1'b0;
      // a fresh empty edge or a new enable wins over the service read
      if ((THR_EMPTY_I && !thre_last_q) || (wr_ie && WDATA_I[`MPI_IE_THRE] && !ie_q[`MPI_IE_THRE]))
         thre_d = THR_EMPTY_I;
      if (mrst)
         thre_d = 1'b0;
   end

   // empty holding register flag
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         thre_q      <= 1'b0;
         thre_last_q <= 1'b0;
      end
      else
      begin
         thre_q      <= thre_d;
         thre_last_q <= thre_last_d;
      end
   end

   // next output values
   always_comb
   begin
      rdata_d = `MPI_RST_BYTE;
      case (ADDR_I)
         `MPI_ADDR_INT_ENABLE: rdata_d = {4'h0, ie_q};
         `MPI_ADDR_INT_IDENT:  rdata_d = ident_code;
         `MPI_ADDR_MODEM_CTRL: rdata_d = {3'h0, mc_q};
         `MPI_ADDR_MODEM_STAT: rdata_d = stat_byte;
         default:              rdata_d = `MPI_RST_BYTE;
      endcase
      if (!RD_I)
         rdata_d = `MPI_RST_BYTE;
      drv_off_n_d = RD_I;
      dtr_n_d     = ~(mc_d[`MPI_MC_DTR] && !mc_d[`MPI_MC_LOOP]);
      usr_a_n_d   = ~(mc_d[`MPI_MC_USER_A] && !mc_d[`MPI_MC_LOOP]);
      usr_b_n_d   = ~(mc_d[`MPI_MC_USER_B] && !mc_d[`MPI_MC_LOOP]);
      int_d       = (cause != mpi_pkg::MPI_CAUSE_NONE);
      if (mrst)
      begin
         rdata_d     = `MPI_RST_BYTE;
         drv_off_n_d = 1'b0;
         dtr_n_d     = 1'b1;
         usr_a_n_d   = 1'b1;
         usr_b_n_d   = 1'b1;
         int_d       = 1'b0;
      end
   end

   // output flops
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         rdata_q     <= `MPI_RST_BYTE;
         drv_off_n_q <= 1'b0;
         dtr_n_q     <= 1'b1;
         usr_a_n_q   <= 1'b1;
         usr_b_n_q   <= 1'b1;
         int_q       <= 1'b0;
      end
      else
      begin
         rdata_q     <= rdata_d;
         drv_off_n_q <= drv_off_n_d;
         dtr_n_q     <= dtr_n_d;
         usr_a_n_q   <= usr_a_n_d;
         usr_b_n_q   <= usr_b_n_d;
         int_q       <= int_d;
      end
   end

   // ports straight from flops
   assign RDATA_O            = rdata_q;
   assign XCVR_DRIVE_OFF_N_O = drv_off_n_q;
   assign DTR_N_O            = dtr_n_q;
   assign RTS_CTRL_O         = mc_q[`MPI_MC_RTS];
   assign LOOP_O             = loop_on;
   assign USER_OUTPUT_A_N_O  = usr_a_n_q;
   assign USER_OUTPUT_B_N_O  = usr_b_n_q;
   assign INT_O              = int_q;

endmodule
`default_nettype wire

// ===== verif/mpi_asserts.sv
// port checker for the modem pin block
`timescale 1ns/100ps
`default_nettype none

module mpi_asserts
(
   input wire logic       CLK_I,              // clock
   input wire logic       RESETN_I,           // reset
   input wire logic       MASTER_RESET_I,     // master reset
   input wire logic [2:0] ADDR_I,             // address
   input wire logic [7:0] WDATA_I,            // write data
   input wire logic       WR_I,               // write
   input wire logic       RD_I,               // read
   input wire logic [7:0] RDATA_O,            // read data
   input wire logic       DCD_N_I,            // carrier pin
   input wire logic       DSR_N_I,            // ready pin
   input wire logic       DTR_N_O,            // terminal ready
   input wire logic       LOOP_O,             // loop bit
   input wire logic       USER_OUTPUT_A_N_O,  // user a
   input wire logic       USER_OUTPUT_B_N_O,  // user b
   input wire logic       XCVR_DRIVE_OFF_N_O, // drive off
   input wire logic       INT_O               // interrupt
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   // bus decode
   logic st_rd;
   logic mc_wr;
   assign st_rd = RD_I && ADDR_I == 3'h6;
   assign mc_wr = WR_I && ADDR_I == 3'h4;

   // pins quiet long enough to be through the synchroniser
   sequence calm_s;
      (!MASTER_RESET_I && $stable(DCD_N_I) && $stable(DSR_N_I))[*4];
   endsequence

   a_drive_off_rd: assert property (RD_I |=> XCVR_DRIVE_OFF_N_O)
      else $error("drive off not high in read data cycle");
   a_drive_off_idle: assert property (!RD_I |=> !XCVR_DRIVE_OFF_N_O)
      else $error("drive off high outside a read");
   a_dtr_write: assert property ((!MASTER_RESET_I)[*3] ##0 mc_wr |=>
      DTR_N_O == !($past(WDATA_I[0]) && !$past(WDATA_I[4]))) else $error("terminal ready wrong after write");
   a_user_write: assert property ((!MASTER_RESET_I)[*3] ##0 mc_wr |=>
      {USER_OUTPUT_B_N_O, USER_OUTPUT_A_N_O} == ({2{$past(WDATA_I[4])}} | ~$past(WDATA_I[3:2])))
      else $error("user outputs wrong after write");
   a_loop_quiet: assert property (LOOP_O |-> DTR_N_O && USER_OUTPUT_A_N_O && USER_OUTPUT_B_N_O)
      else $error("output active in loop mode");
   a_mreset_out: assert property (MASTER_RESET_I[*4] |=>
      DTR_N_O && USER_OUTPUT_A_N_O && USER_OUTPUT_B_N_O && !INT_O && !LOOP_O)
      else $error("outputs not at reset level in master reset");
   a_status_level: assert property (calm_s ##0 st_rd |=>
      RDATA_O[7] == !$past(DCD_N_I) && RDATA_O[5] == !$past(DSR_N_I)) else $error("status levels wrong");
   a_delta_clear: assert property (calm_s ##0 st_rd ##1 st_rd |=>
      !RDATA_O[3] && !RDATA_O[1]) else $error("change flag not cleared by read");

   // main scenarios
   cover property (st_rd ##1 RDATA_O[3]);
   cover property (mc_wr && WDATA_I[4]);
   cover property ($rose(INT_O));
endmodule

bind mpi_top mpi_asserts u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .MASTER_RESET_I(MASTER_RESET_I),
   .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .DCD_N_I(DCD_N_I),
   .DSR_N_I(DSR_N_I), .DTR_N_O(DTR_N_O), .LOOP_O(LOOP_O), .USER_OUTPUT_A_N_O(USER_OUTPUT_A_N_O),
   .USER_OUTPUT_B_N_O(USER_OUTPUT_B_N_O), .XCVR_DRIVE_OFF_N_O(XCVR_DRIVE_OFF_N_O), .INT_O(INT_O));
`default_nettype wire

// ===== verif/mpi_modem_model.sv
// modem model driving the carrier and ready pins
`timescale 1ns/100ps
`default_nettype none

module mpi_modem_model
(
   input  wire logic       clk_i,     // bench clock
   input  wire logic       carrier_i, // carrier present
   input  wire logic [3:0] lag_i,     // cycles from terminal ready to data set ready
   input  wire logic       dtr_n_i,   // terminal ready pin
   output var  logic       dcd_n_o,   // carrier pin, active low
   output var  logic       dsr_n_o    // ready pin, active low
);
   logic [3:0] cnt;

   // idle: no carrier, not ready
   initial
   begin
      dcd_n_o = 1'h1;
      dsr_n_o = 1'h1;
      cnt = 4'h0;
   end

   // answers terminal ready after lag; pins move 7 ns off the edge
   always @(posedge clk_i)
   begin
      cnt <= dtr_n_i ? 4'h0 : (cnt == lag_i ? cnt : cnt + 4'h1);
      dcd_n_o <= #7 !carrier_i;
      dsr_n_o <= #7 !(!dtr_n_i && cnt == lag_i);
   end
endmodule
`default_nettype wire

// ===== verif/mpi_top_tb_top.sv
// self-checking bench for the modem pin block
`timescale 1ns/100ps
`default_nettype none

module mpi_top_tb_top;
   typedef struct {logic [7:0] ie, mc, id; logic [4:0] c; logic [2:0] pins;} mpi_row_t;
   logic       clk = 1'h0, resetn = 1'h0, mrst = 1'h0, wr_s = 1'h0, rd_s = 1'h0, carrier = 1'h0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, rdata, got, prev;
   logic [4:0] cause = 5'h00; // fifo, thr, timeout, avail, error
   logic [3:0] lag = 4'h1;
   logic       dcd_n, dsr_n, dtr_n, ua_n, ub_n, xoff_n, irq, rts, loop_on;
   int         num_errors = 0, n_tests = 0;
   // ie, control, ident, causes, {dtr, user a, user b}
   mpi_row_t rows [6] = '{'{8'h04, 8'h01, 8'h06, 5'h01, 3'h3}, '{8'h01, 8'h04, 8'h04, 5'h02, 3'h5},
      '{8'h01, 8'h08, 8'hcc, 5'h14, 3'h6}, '{8'h02, 8'h0f, 8'h02, 5'h08, 3'h0},
      '{8'h00, 8'h1d, 8'h01, 5'h01, 3'h7}, '{8'h00, 8'h00, 8'h01, 5'h00, 3'h7}};

   always #12.5 clk = ~clk;

   mpi_top i_dut (.CLK_I(clk), .RESETN_I(resetn), .MASTER_RESET_I(mrst), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .DCD_N_I(dcd_n), .DSR_N_I(dsr_n), .RX_ERROR_I(cause[0]),
      .RX_AVAIL_I(cause[1]), .RX_TIMEOUT_I(cause[2]), .FIFO_MODE_I(cause[4]), .THR_EMPTY_I(cause[3]),
      .DTR_N_O(dtr_n), .RTS_CTRL_O(rts), .LOOP_O(loop_on), .USER_OUTPUT_A_N_O(ua_n), .USER_OUTPUT_B_N_O(ub_n),
      .XCVR_DRIVE_OFF_N_O(xoff_n), .INT_O(irq));

   mpi_modem_model i_modem (.clk_i(clk), .carrier_i(carrier), .lag_i(lag), .dtr_n_i(dtr_n),
      .dcd_n_o(dcd_n), .dsr_n_o(dsr_n));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // one write, then an idle cycle
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'h1;
      tick(1);
      wr_s <= 1'h0;
      tick(1);
   endtask

   // n back-to-back reads, then an idle cycle
   task automatic rd(input logic [2:0] a, input int n);
      addr <= a;
      rd_s <= 1'h1;
      repeat (n)
      begin
         tick(1);
         prev = got;
         got = rdata;
         chk({7'h00, xoff_n}, 8'h01, "drive off in read");
      end
      rd_s <= 1'h0;
      tick(1);
      chk({7'h00, xoff_n}, 8'h00, "drive off idle");
   endtask

   task automatic wait_irq;
      for (int k = 0; k < 30 && !irq; k++)
         tick(1);
   endtask

   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // watchdog
   initial
   begin
      #(25 * 5000);
      num_errors++;
      print_verdict;
   end

   // main sequence
   initial
   begin
      tick(6);
      chk({3'h0, dtr_n, ua_n, ub_n, irq, xoff_n}, 8'h1c, "reset levels");
      resetn = 1'h1;
      tick(4);
      rd(3'h6, 1);
      chk(got, 8'h00, "status after reset");
      $display("reset done");
      foreach (rows[i])
      begin
         wr(3'h4, rows[i].mc);
         cause <= rows[i].c;
         tick(1);
         wr(3'h1, rows[i].ie);
         tick(2);
         chk({7'h00, irq}, {7'h00, ~rows[i].id[0]}, "cause int");
         rd(3'h2, 1);
         chk(got, rows[i].id, "ident");
         tick(1);
         chk({7'h00, irq}, {7'h00, ~rows[i].id[0] && rows[i].id != 8'h02}, "int serviced");
         rd(3'h4, 1);
         chk(got, rows[i].mc, "control");
         chk({5'h00, dtr_n, ua_n, ub_n}, {5'h00, rows[i].pins}, "pins");
         chk({6'h00, rts, loop_on}, {6'h00, rows[i].mc[1], rows[i].mc[4]}, "control outputs");
         cause <= 5'h00;
         wr(3'h1, 8'h00);
      end
      rd(3'h7, 1);
      chk(got, 8'h00, "unmapped");
      $display("table done");
      lag <= 4'h5;
      wr(3'h4, 8'h00);
      tick(10);
      rd(3'h6, 2);
      wr(3'h1, 8'h08);
      carrier <= 1'h1;
      wait_irq;
      chk({7'h00, irq}, 8'h01, "carrier int");
      rd(3'h6, 2);
      chk(prev, 8'h88, "carrier on");
      chk(got, 8'h80, "flag cleared");
      chk({7'h00, irq}, 8'h00, "carrier serviced");
      wr(3'h4, 8'h01);
      wait_irq;
      chk({7'h00, irq}, 8'h01, "ready int");
      rd(3'h6, 2);
      chk(prev, 8'ha2, "ready on");
      chk(got, 8'ha0, "ready cleared");
      wr(3'h1, 8'h00);
      carrier <= 1'h0;
      tick(8);
      chk({7'h00, irq}, 8'h00, "masked change");
      rd(3'h6, 1);
      chk(got, 8'h28, "carrier off");
      $display("modem done");
      cause <= 5'h08;
      wr(3'h4, 8'h0d);
      wr(3'h1, 8'h02);
      tick(2);
      chk({7'h00, irq}, 8'h01, "thr int");
      mrst <= 1'h1;
      tick(5);
      chk({4'h0, dtr_n, ua_n, ub_n, irq}, 8'h0e, "master reset");
      wr(3'h4, 8'h01);
      mrst <= 1'h0;
      tick(4);
      rd(3'h4, 1);
      chk(got, 8'h00, "control after master reset");
      chk({7'h00, irq}, 8'h00, "int after master reset");
      $display("master reset done");
      print_verdict;
   end
endmodule
`default_nettype wire
